// [design/pin_sync.sv]
`timescale 1ns/1ps
// three-stage pin synchroniser; a change counts once stage two and three agree
module pin_sync #(
    parameter logic RESET_VALUE = 1'b0
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // pin and filtered level
    input  wire logic pin,
    output logic      level
);
    logic stage1;
    logic stage2;
    logic stage3;

    // shift chain
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stage1 <= RESET_VALUE;
            stage2 <= RESET_VALUE;
            stage3 <= RESET_VALUE;
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // accept only an agreed level
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            level <= RESET_VALUE;
        end else if (stage2 == stage3) begin
            level <= stage3;
        end
    end
endmodule // pin_sync

// [design/serial_port_address_and_alert.sv]
`timescale 1ns/1ps
// Notes on behaviour
// [RULE_01] enable bit gates load strobe into DAC transfer
// [RULE_02] load pin enabled out of reset
// [RULE_03] alert follows any limit, polarity selectable
// [RULE_04] alert active low default, open drain
// [RULE_05] read data shifts out on falling clock
// [RULE_06] write data sampled on rising clock
// [RULE_07] strap level picks one of three addresses
// [RULE_08] address latched eighth clock, second valid frame
// [RULE_09] latched address ignores later strap changes
// [RULE_10] chip select low frames each serial transfer
// [RULE_11] load falling edge updates pending DACs, 20ns
module serial_port_address_and_alert
    import serial_port_pkg::*;
#(
    parameter int CHANNELS = 4
) (
    // core clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      rst_n,
    // serial link, clocked by its own serial clock
    input  wire logic                      serial_clk,
    input  wire logic                      chip_select_n,
    input  wire logic                      data_in,
    output logic                           data_out_o,
    output logic                           data_out_oe,
    input  wire logic                      two_wire_mode,
    // address strap and addressed-frame indication from the bus decoder
    input  wire logic [1:0]                addr_strap,
    input  wire logic                      frame_start,
    output logic [6:0]                     bus_address,
    output logic                           address_latched,
    // register data for reads, received bytes for writes
    input  wire logic [7:0]                read_data,
    output logic [7:0]                     write_data,
    output logic                           write_valid,
    // load strobe and DAC update
    input  wire logic                      dac_load_strobe_n,
    input  wire logic                      load_pin_enable_bit,
    input  wire logic [CHANNELS-1:0]       input_reg_new,
    output logic [CHANNELS-1:0]            dac_update,
    // limit alert
    input  wire serial_port_pkg::limit_flags_type limits,
    input  wire logic                      alert_active_high,
    output logic                           alert_o,
    output logic                           alert_oe
);
    import serial_port_pkg::*;

    // frame indication brought into the core domain
    logic       cs_s1;
    logic       cs_s2;
    logic       cs_s3;
    logic [7:0] read_hold;

    // read byte frozen while a frame is open, so the link never sees it move
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cs_s1     <= 1'b1;
            cs_s2     <= 1'b1;
            cs_s3     <= 1'b1;
            read_hold <= 8'hFF;
        end else begin
            cs_s1 <= chip_select_n;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
            if (cs_s2 && cs_s3) begin
                read_hold <= read_data;  // settled before the frame opens
            end
        end
    end

    // ---------------- serial clock domain ----------------
    logic [2:0] bit_count;
    logic [7:0] rx_shift;
    logic [7:0] tx_shift;
    logic       rx_toggle;
    logic [7:0] rx_hold;
    logic [3:0] frame_bits;

    // rising-edge sampling of write data inside a frame
    always_ff @(posedge serial_clk or posedge chip_select_n) begin
        if (chip_select_n) begin
            bit_count <= 3'h0;
        end else begin
            bit_count <= bit_count + 3'h1;  // RULE_06
        end
    end

    always_ff @(posedge serial_clk) begin
        if (!chip_select_n) begin  // RULE_10
            rx_shift <= {rx_shift[6:0], data_in};  // RULE_06
        end
    end

    // completed byte held for the core side
    always_ff @(posedge serial_clk) begin
        if (!chip_select_n && bit_count == 3'h7) begin
            rx_hold <= {rx_shift[6:0], data_in};
        end
    end

    // toggle marks each completed byte; cleared on the reset level since
    // the link clock stands still while reset is applied
    always_ff @(posedge serial_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_toggle <= 1'b0;
        end else if (!chip_select_n && bit_count == 3'h7) begin
            rx_toggle <= ~rx_toggle;
        end
    end

    // falling-edge shift of read data
    always_ff @(negedge serial_clk or posedge chip_select_n) begin
        if (chip_select_n) begin
            tx_shift <= 8'hFF;
        end else if (bit_count == 3'h0) begin
            tx_shift <= read_hold;  // RULE_05
        end else begin
            tx_shift <= {tx_shift[6:0], 1'b1};  // RULE_05
        end
    end

    // open drain data out: only pulls low while framed in four-wire mode
    assign data_out_o  = 1'b0;
    assign data_out_oe = !chip_select_n && !two_wire_mode && !tx_shift[7];  // RULE_05

    // eighth serial clock of each frame in two-wire mode
    always_ff @(posedge serial_clk or posedge frame_start) begin
        if (frame_start) begin
            frame_bits <= 4'h0;
        end else if (frame_bits != LATCH_BIT_INDEX) begin
            frame_bits <= frame_bits + 4'h1;
        end
    end

    logic eighth_toggle;

    // toggle on the eighth rising clock of each addressed frame
    always_ff @(posedge serial_clk or negedge rst_n) begin
        if (!rst_n) begin
            eighth_toggle <= 1'b0;
        end else if (two_wire_mode && frame_bits == LATCH_BIT_INDEX - 4'h1) begin
            eighth_toggle <= ~eighth_toggle;  // RULE_08
        end
    end

    // ---------------- core clock domain ----------------
    logic rx_tog_s1;
    logic rx_tog_s2;
    logic rx_tog_s3;
    logic eig_s1;
    logic eig_s2;
    logic eig_s3;

    // toggle synchronisers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rx_tog_s1 <= 1'b0;
            rx_tog_s2 <= 1'b0;
            rx_tog_s3 <= 1'b0;
            eig_s1    <= 1'b0;
            eig_s2    <= 1'b0;
            eig_s3    <= 1'b0;
        end else begin
            rx_tog_s1 <= rx_toggle;
            rx_tog_s2 <= rx_tog_s1;
            rx_tog_s3 <= rx_tog_s2;
            eig_s1    <= eighth_toggle;
            eig_s2    <= eig_s1;
            eig_s3    <= eig_s2;
        end
    end

    // received byte delivered as a one-cycle strobe
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            write_data  <= 8'h00;
            write_valid <= 1'b0;
        end else begin
            write_valid <= rx_tog_s2 ^ rx_tog_s3;  // RULE_06
            if (rx_tog_s2 ^ rx_tog_s3) begin
                write_data <= rx_hold;
            end
        end
    end

    // strap decode
    function automatic logic [6:0] strap_address(input logic [1:0] level);
        case (level)
            STRAP_LOW:   strap_address = ADDR_STRAP_LOW;
            STRAP_HIGH:  strap_address = ADDR_STRAP_HIGH;
            default:     strap_address = ADDR_STRAP_FLOAT;
        endcase
    endfunction

    logic [1:0] frame_count;
    logic [1:0] strap_s1;
    logic [1:0] strap_s2;
    logic [1:0] strap_s3;
    logic [1:0] strap_level;

    // strap pins: three stages, accept once two and three agree
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            strap_s1    <= STRAP_FLOAT;
            strap_s2    <= STRAP_FLOAT;
            strap_s3    <= STRAP_FLOAT;
            strap_level <= STRAP_FLOAT;
        end else begin
            strap_s1 <= addr_strap;
            strap_s2 <= strap_s1;
            strap_s3 <= strap_s2;
            if (strap_s2 == strap_s3) begin
                strap_level <= strap_s3;
            end
        end
    end

    // address follows strap until latched on second valid frame
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            frame_count     <= 2'h0;
            address_latched <= 1'b0;
            bus_address     <= ADDR_STRAP_FLOAT;
        end else if (!address_latched) begin
            bus_address <= strap_address(strap_level);  // RULE_07
            if (eig_s2 ^ eig_s3) begin
                frame_count <= frame_count + 2'h1;
                if (frame_count == 2'(ADDR_LATCH_COUNT - 1)) begin
                    address_latched <= 1'b1;  // RULE_08
                end
            end
        end  // held once latched: RULE_09
    end

    // load strobe
    logic load_level;
    logic load_prev;
    logic [7:0] low_count;

    pin_sync #(
        .RESET_VALUE (1'b1)
    ) u_load_sync (
        .clk   (core_clk),
        .rst_n (rst_n),
        .pin   (dac_load_strobe_n),
        .level (load_level)
    );

    // low-time count qualifies each strobe
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            load_prev <= 1'b1;
            low_count <= 8'h00;
        end else begin
            load_prev <= load_level;
            if (load_level) begin
                low_count <= 8'h00;
            end else if (load_prev) begin
                low_count <= 8'h01;  // falling edge opens a fresh low period
            end else if (low_count != 8'hFF) begin
                low_count <= low_count + 8'h01;
            end
        end
    end

    // enable bit defaults on, so the pin owns loading after reset
    logic load_enable;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            load_enable <= LOAD_PIN_ENABLE_RESET;  // RULE_02
        end else begin
            load_enable <= load_pin_enable_bit;
        end
    end

    // update pulse for pending channels once the low pulse is long enough
    logic load_fire;
    assign load_fire = load_enable && !load_level &&
                       low_count == 8'(LOAD_MIN_LOW_CYC - 1);  // RULE_11

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_update
            always_ff @(posedge core_clk) begin
                if (!rst_n) begin
                    dac_update[ch] <= 1'b0;
                end else begin
                    dac_update[ch] <= load_fire && input_reg_new[ch];  // RULE_01
                end
            end
        end
    endgenerate

    // alert: any limit, polarity chosen, drive low only
    logic alert_any;
    logic alert_pol;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            alert_any <= 1'b0;
            alert_pol <= ALERT_HIGH_RESET;  // RULE_04
        end else begin
            alert_any <= |limits;  // RULE_03
            alert_pol <= alert_active_high;  // RULE_03
        end
    end

    // pull low when the asserted level is low
    assign alert_o  = 1'b0;
    assign alert_oe = alert_pol ? !alert_any : alert_any;  // RULE_04

endmodule // serial_port_address_and_alert

// [design/serial_port_pkg.sv]
package serial_port_pkg;

    // two-wire addresses picked by the three-level strap
    localparam logic [6:0] ADDR_STRAP_LOW   = 7'h48;  // 1001 000
    localparam logic [6:0] ADDR_STRAP_FLOAT = 7'h4A;  // 1001 010
    localparam logic [6:0] ADDR_STRAP_HIGH  = 7'h4B;  // 1001 011

    // strap pin levels as seen by the pad
    localparam logic [1:0] STRAP_LOW   = 2'h0;
    localparam logic [1:0] STRAP_FLOAT = 2'h1;
    localparam logic [1:0] STRAP_HIGH  = 2'h2;

    // reset values of the loose control bits
    localparam logic LOAD_PIN_ENABLE_RESET = 1'b1;
    localparam logic ALERT_HIGH_RESET      = 1'b0;

    // serial frame shape
    localparam int   FRAME_BITS       = 8;
    localparam int   ADDR_LATCH_COUNT = 2;
    localparam logic [3:0] LATCH_BIT_INDEX = 4'h8;  // eighth serial clock

    // load strobe least low time
    localparam int CORE_CLK_MHZ      = 200;
    localparam int LOAD_MIN_LOW_NS   = 20;
    localparam int LOAD_MIN_LOW_CYC  = (LOAD_MIN_LOW_NS * CORE_CLK_MHZ + 999) / 1000;

    // limit events
    typedef struct packed {
        logic temp_over;
        logic supply_over;
        logic analog_input_channel_over;
    } limit_flags_type;

    // byte moved from the serial side into the core side
    typedef struct packed {
        logic       valid_toggle;
        logic [7:0] data;
    } rx_word_type;

endpackage

// [verif/serial_host_model.sv]
`timescale 1ns/1ps
// host side of the serial link; clock idles high and stands still between frames
module serial_host_model (
    // serial pins driven by the host
    output logic      serial_clk,
    output logic      chip_select_n,
    output logic      data_in,
    output logic      frame_start,
    // open-drain data line, pulled low by the device
    input  wire logic data_out_oe
);
    initial begin
        serial_clk = 1'b1;
        chip_select_n = 1'b1;
        data_in = 1'b1;
        frame_start = 1'b0;
    end
    // one framed byte, msb first; data moves after the falling edge
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        chip_select_n = 1'b0;
        #15;
        for (int i = 7; i >= 0; i--) begin
            serial_clk = 1'b0;
            data_in = tx[i];
            #15;
            serial_clk = 1'b1;
            rx[i] = ~data_out_oe; // line with pull-up
            #15;
        end
        chip_select_n = 1'b1;
        data_in = 1'b1; // released, pull-up
    endtask
    // addressed two-wire frame: decoder pulse, then eight clocks
    task automatic tw_frame();
        frame_start = 1'b1;
        #10;
        frame_start = 1'b0;
        for (int i = 0; i < 8; i++) begin
            serial_clk = 1'b0;
            #15;
            serial_clk = 1'b1;
            #15;
        end
        #60;
    endtask
endmodule // serial_host_model

// [verif/serial_port_address_and_alert_chk.sv]
`timescale 1ns/1ps
module serial_port_address_and_alert_chk
    import serial_port_pkg::*;
#(
    parameter int CHANNELS = 4
) (
    // clock and reset
    input wire logic                  core_clk,
    input wire logic                  rst_n,
    // serial side
    input wire logic                  chip_select_n,
    input wire logic                  two_wire_mode,
    input wire logic                  data_out_o,
    input wire logic                  data_out_oe,
    input wire logic                  write_valid,
    // address
    input wire logic [1:0]            addr_strap,
    input wire logic [6:0]            bus_address,
    input wire logic                  address_latched,
    // load and alert
    input wire logic                  dac_load_strobe_n,
    input wire logic                  load_pin_enable_bit,
    input wire logic [CHANNELS-1:0]   dac_update,
    input wire serial_port_pkg::limit_flags_type limits,
    input wire logic                  alert_active_high,
    input wire logic                  alert_o,
    input wire logic                  alert_oe
);
    logic [1:0] up;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // cycles since reset release, saturating
    always_ff @(posedge core_clk) begin
        if (!rst_n) up <= 2'h0;
        else if (up != 2'h3) up <= up + 2'h1;
    end
    function automatic logic [6:0] addr_of(logic [1:0] s);
        return (s == STRAP_LOW) ? ADDR_STRAP_LOW : (s == STRAP_HIGH) ? ADDR_STRAP_HIGH
            : ADDR_STRAP_FLOAT;
    endfunction
    alert_polarity_a: assert property (up == 2'h3 |-> alert_oe ==
        ($past(|limits, 1) ^ $past(alert_active_high, 1))) else $error("alert level wrong");
    alert_open_drain_a: assert property (alert_o == 1'b0) else $error("alert drives high");
    dout_frame_a: assert property ($past(chip_select_n) && chip_select_n |-> !data_out_oe)
        else $error("data out driven outside frame");
    dout_mode_a: assert property (two_wire_mode |-> !data_out_oe && !data_out_o)
        else $error("data out driven in two-wire mode");
    load_gate_a: assert property (|dac_update |-> $past(load_pin_enable_bit, 2)
        && !$past(dac_load_strobe_n, 5) && !$past(dac_load_strobe_n, 8))
        else $error("dac update without enabled strobe");
    update_pulse_a: assert property (|dac_update |=> dac_update == '0)
        else $error("dac update longer than one cycle");
    write_pulse_a: assert property (write_valid |=> !write_valid)
        else $error("write valid longer than one cycle");
    addr_follow_a: assert property ((!address_latched && $stable(addr_strap))[*6] |->
        bus_address == addr_of(addr_strap)) else $error("address does not follow strap");
    addr_hold_a: assert property (address_latched |=> address_latched && $stable(bus_address))
        else $error("latched address changed");
    cover property (write_valid);
    cover property ($rose(address_latched));
    cover property (|dac_update);
endmodule // serial_port_address_and_alert_chk
bind serial_port_address_and_alert serial_port_address_and_alert_chk #(.CHANNELS(CHANNELS)) u_chk (
    .core_clk, .rst_n, .chip_select_n, .two_wire_mode, .data_out_o, .data_out_oe, .write_valid,
    .addr_strap, .bus_address, .address_latched, .dac_load_strobe_n, .load_pin_enable_bit,
    .dac_update, .limits, .alert_active_high, .alert_o, .alert_oe);

// [verif/serial_port_address_and_alert_tb_top.sv]
`timescale 1ns/1ps
`define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
    $display("Error %s expected %h seen %h", nm, e, a); end end
module serial_port_address_and_alert_tb_top;
    import serial_port_pkg::*;
    logic core_clk, rst_n, serial_clk, chip_select_n, data_in, data_out_o, data_out_oe;
    logic two_wire_mode, frame_start, address_latched, write_valid, dac_load_strobe_n;
    logic load_pin_enable_bit, alert_active_high, alert_o, alert_oe;
    logic [1:0] addr_strap;
    logic [6:0] bus_address;
    logic [7:0] read_data, write_data, got, rx;
    logic [3:0] input_reg_new, dac_update, acc;
    limit_flags_type limits;
    int miscompares, comparisons, nwv;
    serial_port_address_and_alert u_dut (.core_clk, .rst_n, .serial_clk, .chip_select_n,
        .data_in, .data_out_o, .data_out_oe, .two_wire_mode, .addr_strap, .frame_start,
        .bus_address, .address_latched, .read_data, .write_data, .write_valid,
        .dac_load_strobe_n, .load_pin_enable_bit, .input_reg_new, .dac_update, .limits,
        .alert_active_high, .alert_o, .alert_oe);
    serial_host_model u_host (.serial_clk, .chip_select_n, .data_in, .frame_start, .data_out_oe);
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // collect received bytes and dac update pulses
    always @(posedge core_clk) begin
        if (write_valid === 1'b1) begin
            got = write_data;
            nwv++;
        end
        acc = acc | dac_update;
    end
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic report_and_stop();
        if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // strobe low for n cycles, then check which channels updated
    task automatic load(input int n, input logic [3:0] exp);
        acc = 4'h0;
        dac_load_strobe_n = 1'b0;
        step(n);
        dac_load_strobe_n = 1'b1;
        step(15);
        `CHK("dac_update", exp, acc)
    endtask
    initial begin
        rst_n = 1'b0;
        {two_wire_mode, limits, input_reg_new, acc, nwv} = '0;
        {addr_strap, read_data, dac_load_strobe_n} = {STRAP_FLOAT, 8'hA5, 1'b1};
        {load_pin_enable_bit, alert_active_high} = {LOAD_PIN_ENABLE_RESET, ALERT_HIGH_RESET};
        step(4);
        rst_n = 1'b1;
        step(6);
        `CHK("alert_oe", 1'b0, alert_oe)
        `CHK("bus_address", ADDR_STRAP_FLOAT, bus_address)
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 8; i++) begin
                alert_active_high = p[0];
                limits = i[2:0];
                step(4);
                `CHK("alert_oe", (i != 0) ^ p[0], alert_oe)
                `CHK("alert_o", 1'b0, alert_o)
            end
        end
        input_reg_new = 4'h5;
        load(10, 4'h5);
        load_pin_enable_bit = 1'b0;
        load(10, 4'h0);
        load_pin_enable_bit = 1'b1;
        load(2, 4'h0);
        load(3, 4'h0);
        load(4, 4'h5);
        for (int k = 0; k < 2; k++) begin
            read_data = 8'hA5 ^ {8{k[0]}};
            u_host.xfer(8'h3C ^ {8{k[0]}}, rx);
            step(10);
            `CHK("write_data", 8'h3C ^ {8{k[0]}}, got)
            `CHK("data_out", read_data, rx)
            `CHK("write_count", k + 1, nwv)
        end
        two_wire_mode = 1'b1;
        addr_strap = STRAP_HIGH;
        step(8);
        `CHK("bus_address", ADDR_STRAP_HIGH, bus_address)
        u_host.tw_frame();
        step(10);
        `CHK("address_latched", 1'b0, address_latched)
        u_host.tw_frame();
        for (int w = 0; w < 20 && address_latched !== 1'b1; w++) step(1);
        `CHK("address_latched", 1'b1, address_latched)
        u_host.xfer(8'h00, rx);
        `CHK("data_out_two_wire", 8'hFF, rx)
        addr_strap = STRAP_LOW;
        step(8);
        `CHK("bus_address", ADDR_STRAP_HIGH, bus_address)
        rst_n = 1'b0;
        step(4);
        rst_n = 1'b1;
        step(8);
        `CHK("bus_address", ADDR_STRAP_LOW, bus_address)
        report_and_stop();
    end
endmodule // serial_port_address_and_alert_tb_top
